// *** test/host_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
	input  wire logic        i_core_clk,
	input  wire logic        i_bus_16bit,
	input  wire logic [15:0] i_lanes,
	output logic             o_cs_n,
	output logic             o_wr_n,
	output logic             o_rd_n,
	output logic             o_cmd,
	output logic      [15:0] o_lanes
);
	logic [15:0] lane_mask;
	// upper lanes driven low in 8-bit mode after a write and during a read; a write strobe drives all 16 bits of v
	assign lane_mask = i_bus_16bit ? 16'hffff : 16'h00ff;
	initial begin
		{o_cs_n, o_wr_n, o_rd_n, o_cmd} = 4'he;
		o_lanes = 16'h0000;
	end
	task automatic wr(input logic c, input logic [15:0] v);
		@(posedge i_core_clk) #1;
		{o_cmd, o_lanes} = {c, v};
		{o_cs_n, o_wr_n} = 2'b00;
		repeat (4) @(posedge i_core_clk);
		#1;
		{o_cs_n, o_wr_n} = 2'b11;
		o_lanes = ~v & lane_mask;
		repeat (3) @(posedge i_core_clk);
	endtask : wr
	task automatic rd(output logic [15:0] d);
		@(posedge i_core_clk) #1;
		o_cmd = 1'b0;
		o_lanes = ~o_lanes & lane_mask;
		{o_cs_n, o_rd_n} = 2'b00;
		repeat (6) @(posedge i_core_clk);
		d = i_lanes;
		#1;
		{o_cs_n, o_rd_n} = 2'b11;
		repeat (4) @(posedge i_core_clk);
	endtask : rd
endmodule : host_bus_model
`default_nettype wire

// *** test/shared_bus_phase_decoder_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module bus_phase_checker (
	input wire logic                     i_core_clk,
	input wire logic                     i_rst,
	input wire logic                     i_bus_16bit,
	input wire logic [15:0]              i_rd_data,
	input wire logic [15:0]              o_shared_lanes,
	input wire logic [15:0]              o_shared_lanes_oe,
	input wire bus_phase_pkg::cmd_word_t o_cmd_word,
	input wire logic                     o_cmd_valid,
	input wire logic [15:0]              o_wr_data,
	input wire logic                     o_wr_valid,
	input wire logic                     o_rd_strobe
);
	import bus_phase_pkg::*;
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);
	a_cmd_pulse: assert property (o_cmd_valid |=> !o_cmd_valid)
		else $error("cmd valid too long");
	a_wr_pulse: assert property (o_wr_valid |=> !o_wr_valid)
		else $error("wr valid too long");
	a_rd_oe_word: assert property (o_rd_strobe && i_bus_16bit |-> o_shared_lanes_oe == 16'hffff)
		else $error("16-bit read enables wrong");
	a_rd_oe_byte: assert property (o_rd_strobe && !i_bus_16bit |-> o_shared_lanes_oe == 16'h00ff)
		else $error("8-bit read enables wrong");
	a_rd_lane_data: assert property (o_shared_lanes_oe[15] |-> o_shared_lanes == $past(i_rd_data))
		else $error("read lanes wrong");
	a_cmd_word_hold: assert property (!o_cmd_valid |-> $stable(o_cmd_word))
		else $error("cmd word moved");
	a_wr_data_hold: assert property (!o_wr_valid |-> $stable(o_wr_data))
		else $error("wr data moved");
	a_wr_byte_mask: assert property (o_wr_valid && !i_bus_16bit |-> o_wr_data[15:8] == 8'h00)
		else $error("8-bit write upper byte set");
	a_cmd_word_low: assert property (o_cmd_valid && i_bus_16bit |-> o_cmd_word.addr[1:0] == 2'h0)
		else $error("16-bit address low bits set");
	cover property (o_cmd_valid && !i_bus_16bit);
	cover property (o_wr_valid);
	cover property (o_rd_strobe);
endmodule : bus_phase_checker
bind shared_bus_phase_decoder bus_phase_checker bus_phase_checker_inst (.i_core_clk, .i_rst, .i_bus_16bit,
	.i_rd_data, .o_shared_lanes, .o_shared_lanes_oe, .o_cmd_word, .o_cmd_valid, .o_wr_data, .o_wr_valid,
	.o_rd_strobe);
`default_nettype wire

// *** test/test_shared_bus_phase_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_shared_bus_phase_decoder;
	import bus_phase_pkg::*;
	logic        i_core_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        i_bus_16bit = 1'b1;
	logic [15:0] rd_data = 16'h0000;
	logic        cs_n, wr_n, rd_n, cmd, cmd_valid, wr_valid, rd_strobe, pending;
	logic [15:0] host_lanes, wire_lanes, lanes, oe, wr_data, seen;
	cmd_word_t   cmd_word;
	int          n_fail = 0;
	int          n_compared = 0;
	int          n_cmd = 0;
	int          n_wr = 0;
	int          n_rd = 0;
	logic [15:0] oe_seen = 16'h0000;
	always #2 i_core_clk = ~i_core_clk;
	assign wire_lanes = (oe & lanes) | (~oe & host_lanes);
	always @(posedge i_core_clk) begin
		n_cmd <= n_cmd + int'(cmd_valid);
		n_wr <= n_wr + int'(wr_valid);
		n_rd <= n_rd + int'(rd_strobe);
		if (rd_strobe) begin
			oe_seen <= oe;
		end
	end
	shared_bus_phase_decoder shared_bus_phase_decoder_inst (.i_core_clk, .i_rst, .i_cs_n(cs_n),
		.i_wr_n(wr_n), .i_rd_n(rd_n), .i_cmd(cmd), .i_bus_16bit, .i_shared_lanes(wire_lanes),
		.i_rd_data(rd_data), .o_shared_lanes(lanes), .o_shared_lanes_oe(oe), .o_cmd_word(cmd_word),
		.o_cmd_valid(cmd_valid), .o_wr_data(wr_data), .o_wr_valid(wr_valid), .o_rd_strobe(rd_strobe),
		.o_second_pending(pending));
	host_bus_model host_bus_model_inst (.i_core_clk, .i_bus_16bit, .i_lanes(wire_lanes), .o_cs_n(cs_n),
		.o_wr_n(wr_n), .o_rd_n(rd_n), .o_cmd(cmd), .o_lanes(host_lanes));
	task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wr_step(input logic c, input logic [15:0] v, input int ec, input int ew);
		int a;
		int b;
		a = n_cmd;
		b = n_wr;
		host_bus_model_inst.wr(c, v);
		repeat (2) @(posedge i_core_clk);
		#1;
		chk("cmd pulses", 16'(n_cmd - a), 16'(ec));
		chk("wr pulses", 16'(n_wr - b), 16'(ew));
	endtask : wr_step
	task automatic t_data(input logic b16, input logic [15:0] w, input logic [15:0] r);
		logic [15:0] m;
		int          c;
		m = b16 ? 16'hffff : 16'h00ff;
		@(posedge i_core_clk) #1;
		i_bus_16bit = b16;
		wr_step(1'b0, w, 0, 1);
		chk("wr_data", wr_data, w & m);
		rd_data = r;
		c = n_rd;
		host_bus_model_inst.rd(seen);
		chk("rd_data", seen & m, r & m);
		chk("rd strobes", 16'(n_rd - c), 16'h0001);
		chk("rd oe", oe_seen, m);
		$display("t_data done");
	endtask : t_data
	task automatic t_cmd16(input logic [15:0] v);
		@(posedge i_core_clk) #1;
		i_bus_16bit = 1'b1;
		wr_step(1'b1, v, 1, 0);
		chk("cmd16", {1'b0, cmd_word}, {1'b0, v[10:2], 2'b00, v[15:12]});
		wr_step(1'b1, v ^ 16'h0802, 1, 0);
		chk("cmd16 ign", {1'b0, cmd_word}, {1'b0, v[10:2], 2'b00, v[15:12]});
		$display("t_cmd16 done");
	endtask : t_cmd16
	task automatic t_cmd8(input logic [7:0] w1, input logic [7:0] w2);
		logic [10:0] a;
		a = {w2[2:0], w1};
		@(posedge i_core_clk) #1;
		i_bus_16bit = 1'b0;
		wr_step(1'b1, {8'h00, w1}, 0, 0);
		chk("pending 1st", 16'(pending), 16'h0001);
		wr_step(1'b0, 16'h0011, 0, 1);
		chk("pending data", 16'(pending), 16'h0001);
		wr_step(1'b1, {8'h00, w2}, 1, 0);
		chk("pending 2nd", 16'(pending), 16'h0000);
		chk("cmd8", {1'b0, cmd_word}, {1'b0, a, 4'b0001 << a[1:0]});
		wr_step(1'b1, 16'h0042, 0, 0);
		@(posedge i_core_clk) #1;
		i_bus_16bit = 1'b1;
		repeat (4) @(posedge i_core_clk);
		chk("pending width", 16'(pending), 16'h0000);
		$display("t_cmd8 done");
	endtask : t_cmd8
	task automatic print_verdict();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict
	initial begin
		repeat (5) @(posedge i_core_clk);
		#1;
		i_rst = 1'b0;
		t_data(1'b1, 16'ha5c3, 16'h5a3c);
		t_data(1'b0, 16'h003c, 16'h00c9);
		t_cmd16(16'ha9b6);
		t_cmd16(16'h57fd);
		t_cmd8(8'hb5, 8'hfd);
		print_verdict();
	end
	initial begin
		#20000;
		n_fail++;
		print_verdict();
	end
endmodule : test_shared_bus_phase_decoder
`default_nettype wire

// *** verilog/bus_phase_pkg.sv ***
// Functional notes
// - command low: each shared lane in use (all 16 in 16-bit mode, 0 to 7 in 8-bit mode) is the data bit of the same index.
// - 16-bit command phase: lanes 12, 13, 14 carry lane enables 0, 1, 2.
// - command phase: lane 11 is ignored in both bus widths.
// - 16-bit command phase: lanes 2 to 10 carry address bits 2 to 10.
// - 16-bit command phase: lane 1 is ignored; enables replace low address bits.
// - 8-bit mode: first command write carries address bits 1 to 7 on lanes 1 to 7.
// - 8-bit second command write: lane 2 is address 10, lane 1 address 9; 3 to 7 ignored.
// - 8-bit mode: lane 0 is address bit 0 first, address bit 8 second.
// - 16-bit command phase: lane 15 carries lane enable 3.
package bus_phase_pkg;
	localparam int LANE_W = 16;
	localparam int ADDR_W = 11;
	localparam int BE_W   = 4;
	localparam int SYNC_W = 21;

	localparam int LANE_BE0  = 12;
	localparam int LANE_BE3  = 15;
	localparam int LANE_A_LO = 2;
	localparam int LANE_A_HI = 10;
	localparam int BYTE_HI   = 7;
	localparam int LANE_A9   = 1;
	localparam int LANE_A10  = 2;

	localparam logic [LANE_W-1:0] LANES_RST   = 16'h0000;
	localparam logic [LANE_W-1:0] OE_BYTE_LOW = 16'h00ff;
	localparam logic [LANE_W-1:0] OE_WORD     = 16'hffff;
	localparam logic [ADDR_W-1:0] ADDR_RST    = 11'h000;
	localparam logic [BE_W-1:0]   BE_RST      = 4'h0;

	typedef enum logic [1:0] {
		PH_FIRST  = 2'b01,
		PH_SECOND = 2'b10
	} phase_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [BE_W-1:0]   lane_en;
	} cmd_word_t;

	typedef struct packed {
		logic              cs_n;
		logic              wr_n;
		logic              rd_n;
		logic              cmd;
		logic              bus_16bit;
		logic [LANE_W-1:0] shared_lanes;
	} pin_bundle_t;
endpackage : bus_phase_pkg

// *** verilog/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         i_core_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	////////////////////////////////////////////////////////////////////////////
	// two-flop synchroniser per bit
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge i_core_clk or posedge i_rst) begin
				if (i_rst) begin
					meta_q[g] <= 1'b1;
					sync_q[g] <= 1'b1;
				end else begin
					meta_q[g] <= i_async[g];
					sync_q[g] <= meta_q[g];
				end
			end
		end
	endgenerate

	assign o_sync = sync_q;
endmodule : pin_sync
`default_nettype wire

// *** verilog/shared_bus_phase_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module shared_bus_phase_decoder (
	input  wire logic                                 i_core_clk,
	input  wire logic                                 i_rst,
	input  wire logic                                 i_cs_n,
	input  wire logic                                 i_wr_n,
	input  wire logic                                 i_rd_n,
	input  wire logic                                 i_cmd,
	input  wire logic                                 i_bus_16bit,
	input  wire logic [bus_phase_pkg::LANE_W-1:0]     i_shared_lanes,
	input  wire logic [bus_phase_pkg::LANE_W-1:0]     i_rd_data,
	output logic      [bus_phase_pkg::LANE_W-1:0]     o_shared_lanes,
	output logic      [bus_phase_pkg::LANE_W-1:0]     o_shared_lanes_oe,
	output bus_phase_pkg::cmd_word_t                  o_cmd_word,
	output logic                                      o_cmd_valid,
	output logic      [bus_phase_pkg::LANE_W-1:0]     o_wr_data,
	output logic                                      o_wr_valid,
	output logic                                      o_rd_strobe,
	output logic                                      o_second_pending
);
	import bus_phase_pkg::*;

	pin_bundle_t  pins_raw;
	pin_bundle_t  pins_s;
	logic [SYNC_W-1:0] sync_vec;

	assign pins_raw = '{cs_n: i_cs_n, wr_n: i_wr_n, rd_n: i_rd_n, cmd: i_cmd,
		bus_16bit: i_bus_16bit, shared_lanes: i_shared_lanes};

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	pin_sync #(
		.W (SYNC_W)
	) u_pin_sync (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_async    (pins_raw),
		.o_sync     (sync_vec)
	);
	assign pins_s = pin_bundle_t'(sync_vec);

	////////////////////////////////////////////////////////////////////////////
	// lane extraction helpers
	function automatic cmd_word_t decode_wide(input logic [LANE_W-1:0] lanes);
		cmd_word_t w;
		w = '0;
		w.addr[LANE_A_HI:LANE_A_LO] = lanes[LANE_A_HI:LANE_A_LO];
		w.lane_en = lanes[LANE_BE3:LANE_BE0];
		return w;
	endfunction : decode_wide

	function automatic logic [BE_W-1:0] byte_onehot(input logic [1:0] sel);
		logic [BE_W-1:0] oh;
		oh = BE_RST;
		oh[sel] = 1'b1;
		return oh;
	endfunction : byte_onehot

	////////////////////////////////////////////////////////////////////////////
	// strobe tracking
	logic wr_act_q;
	logic wr_act_d;
	logic rd_act_q;
	logic rd_act_d;
	logic cmd_hold_q;
	logic cmd_hold_d;
	logic mode_hold_q;
	logic mode_hold_d;
	logic [LANE_W-1:0] lanes_hold_q;
	logic [LANE_W-1:0] lanes_hold_d;
	logic wr_act;
	logic rd_act;
	logic wr_end;

	assign wr_act = !pins_s.cs_n && !pins_s.wr_n;
	assign rd_act = !pins_s.cs_n && !pins_s.rd_n;
	assign wr_end = wr_act_q && !wr_act;

	always_comb begin
		wr_act_d     = wr_act;
		rd_act_d     = rd_act;
		cmd_hold_d   = cmd_hold_q;
		mode_hold_d  = pins_s.bus_16bit;
		lanes_hold_d = lanes_hold_q;
		if (wr_act) begin
			cmd_hold_d   = pins_s.cmd;
			lanes_hold_d = pins_s.shared_lanes;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_act_q     <= 1'b0;
			rd_act_q     <= 1'b0;
			cmd_hold_q   <= 1'b0;
			mode_hold_q  <= 1'b0;
			lanes_hold_q <= LANES_RST;
		end else begin
			wr_act_q     <= wr_act_d;
			rd_act_q     <= rd_act_d;
			cmd_hold_q   <= cmd_hold_d;
			mode_hold_q  <= mode_hold_d;
			lanes_hold_q <= lanes_hold_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// command and data decode
	phase_t      phase_q;
	phase_t      phase_d;
	logic [BYTE_HI:0] low_addr_q;
	logic [BYTE_HI:0] low_addr_d;
	cmd_word_t   cmd_word_q;
	cmd_word_t   cmd_word_d;
	logic        cmd_valid_q;
	logic        cmd_valid_d;
	logic [LANE_W-1:0] wr_data_q;
	logic [LANE_W-1:0] wr_data_d;
	logic        wr_valid_q;
	logic        wr_valid_d;

	always_comb begin
		phase_d     = phase_q;
		low_addr_d  = low_addr_q;
		cmd_word_d  = cmd_word_q;
		cmd_valid_d = 1'b0;
		wr_data_d   = wr_data_q;
		wr_valid_d  = 1'b0;
		// a width change restarts the two-write sequence
		if (mode_hold_q != pins_s.bus_16bit) begin
			phase_d = PH_FIRST;
		end else if (wr_end && cmd_hold_q) begin
			if (mode_hold_q) begin
				cmd_word_d  = decode_wide(lanes_hold_q);
				cmd_valid_d = 1'b1;
			end else begin
				unique case (phase_q)
					PH_FIRST: begin
						low_addr_d = lanes_hold_q[BYTE_HI:0];
						phase_d    = PH_SECOND;
					end
					PH_SECOND: begin
						cmd_word_d.addr    = {lanes_hold_q[LANE_A10], lanes_hold_q[LANE_A9],
							lanes_hold_q[0], low_addr_q};
						cmd_word_d.lane_en = byte_onehot(low_addr_q[1:0]);
						cmd_valid_d        = 1'b1;
						phase_d            = PH_FIRST;
					end
					default: begin
						phase_d = PH_FIRST;
					end
				endcase
			end
		end else if (wr_end) begin
			wr_data_d  = mode_hold_q ? lanes_hold_q : (lanes_hold_q & OE_BYTE_LOW);
			wr_valid_d = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			phase_q     <= PH_FIRST;
			low_addr_q  <= '0;
			cmd_word_q  <= '{addr: ADDR_RST, lane_en: BE_RST};
			cmd_valid_q <= 1'b0;
			wr_data_q   <= LANES_RST;
			wr_valid_q  <= 1'b0;
		end else begin
			phase_q     <= phase_d;
			low_addr_q  <= low_addr_d;
			cmd_word_q  <= cmd_word_d;
			cmd_valid_q <= cmd_valid_d;
			wr_data_q   <= wr_data_d;
			wr_valid_q  <= wr_valid_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read drive of the shared lanes
	logic [LANE_W-1:0] drv_q;
	logic [LANE_W-1:0] drv_d;
	logic [LANE_W-1:0] oe_q;
	logic [LANE_W-1:0] oe_d;
	logic              rd_strobe_q;
	logic              rd_strobe_d;

	always_comb begin
		drv_d       = LANES_RST;
		oe_d        = LANES_RST;
		rd_strobe_d = rd_act && !rd_act_q && !pins_s.cmd;
		if (rd_act && !pins_s.cmd) begin
			oe_d  = pins_s.bus_16bit ? OE_WORD : OE_BYTE_LOW;
			drv_d = i_rd_data & oe_d;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			drv_q       <= LANES_RST;
			oe_q        <= LANES_RST;
			rd_strobe_q <= 1'b0;
		end else begin
			drv_q       <= drv_d;
			oe_q        <= oe_d;
			rd_strobe_q <= rd_strobe_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign o_shared_lanes    = drv_q;
	assign o_shared_lanes_oe = oe_q;
	assign o_cmd_word        = cmd_word_q;
	assign o_cmd_valid       = cmd_valid_q;
	assign o_wr_data         = wr_data_q;
	assign o_wr_valid        = wr_valid_q;
	assign o_rd_strobe       = rd_strobe_q;
	assign o_second_pending  = phase_q[1];
endmodule : shared_bus_phase_decoder
`default_nettype wire
